/* design/dio_ctrl_consts.svh */
`ifndef DIO_CTRL_CONSTS_SVH
`define DIO_CTRL_CONSTS_SVH

`define DIO_PSW_BUSY_BIT     4'd12
`define DIO_PSW_EXAMINE_BIT  4'd13
`define DIO_PSW_MISSING_BIT  4'd15
`define DIO_STAT_EXTINT_BIT  4'd3
`define DIO_CMD_ARM_BIT      3'd0
`define DIO_CMD_ENABLE_BIT   3'd1
`define DIO_CMD_RAND_BIT     3'd4
`define DIO_CMD_SEQ_BIT      3'd5
`define DIO_CMD_WRITE_BIT    3'd6
`define DIO_CMD_READ_BIT     3'd7
`define DIO_BYTE_SELECTS     16
`define DIO_ADDR_RESET       8'h00
`define DIO_CMD_RESET        8'h00
`define DIO_MODSEL_RESET     8'h00
`define DIO_ACK_WAIT_CYCLES  4'd8

`endif

/* design/dio_ctrl_pkg.sv */
`default_nettype none

package dio_ctrl_pkg;

    typedef struct packed {
        logic       addressPhaseStrobe;
        logic       commandStrobe;
        logic       writeDataStrobe;
        logic       readDataStrobe;
        logic       statusReadStrobe;
        logic [7:0] busData;
    } bus_req_t;

    typedef struct packed {
        logic        transferSyncReply;
        logic [15:0] readReturnLines;
    } bus_rsp_t;

    typedef enum logic [2:0] {
        XFER_IDLE  = 3'b001,
        XFER_WAIT  = 3'b010,
        XFER_BUSY  = 3'b100
    } xfer_state_t;

endpackage

`default_nettype wire

/* design/byte_select_decoder.sv */
`timescale 1ns/10ps
`default_nettype none
`include "dio_ctrl_consts.svh"

module byte_select_decoder (
    input  wire logic                          clk_sys,
    input  wire logic                          rst_b,
    input  wire logic                          clkEn,
    input  wire logic                          strobe,
    input  wire logic [3:0]                    byteAddr,
    output logic      [`DIO_BYTE_SELECTS-1:0]  byteSelect
);

    logic [`DIO_BYTE_SELECTS-1:0] selectD;

    // One select per byte, exactly one while strobe
    genvar i;
    generate
        for (i = 0; i < `DIO_BYTE_SELECTS; i++) begin : g_sel
            assign selectD[i] = strobe && (byteAddr == 4'(i));
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            byteSelect <= '0;
        end else if (clkEn) begin
            byteSelect <= selectD;
        end
    end

    a_select_onehot: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $countones(byteSelect) <= 1)
        else $error("More than one byte select active");
    a_select_follows: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (clkEn && strobe) |=> byteSelect[$past(byteAddr)])
        else $error("Addressed byte select missing");

endmodule

`default_nettype wire

/* design/dio_ctrl_host_port.sv */
`timescale 1ns/10ps
`default_nettype none
`include "dio_ctrl_consts.svh"

module dio_ctrl_host_port (
    input  wire logic                   clk_sys,
    input  wire logic                   rst_b,
    input  wire logic                   clkEn,
    input  wire dio_ctrl_pkg::bus_req_t busReq,
    input  wire logic                   requestAckChainIn,
    input  wire logic [7:0]             deviceAddress,
    input  wire logic                   externalInt,
    input  wire logic                   moduleAck,
    input  wire logic [7:0]             inputModuleData,
    input  wire logic                   transferDone,
    output dio_ctrl_pkg::bus_rsp_t      busRsp,
    output logic                        requestAckChainOut,
    output logic                        attentionRequest,
    output logic [7:0]                  outputData,
    output logic [15:0]                 byteSelect,
    output logic [3:0]                  moduleSelect,
    output logic                        moduleReadMode,
    output logic [7:0]                  commandByte,
    output logic                        transferBusyFlag,
    output logic                        externalIntFlag,
    output logic                        missingModuleFlag
);

    // Two-flop synchronisers for all pins from the bus
    logic [13:0] pinMeta_q;
    logic [13:0] pinSync_q;
    logic [13:0] pinRaw;
    logic [13:0] pinSyncPrev_q;

    assign pinRaw = {busReq, requestAckChainIn};

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            pinMeta_q     <= '0;
            pinSync_q     <= '0;
            pinSyncPrev_q <= '0;
        end else if (clkEn) begin
            pinMeta_q     <= pinRaw;
            pinSync_q     <= pinMeta_q;
            pinSyncPrev_q <= pinSync_q;
        end
    end

    logic       addrStrobe;
    logic       cmdStrobe;
    logic       wrStrobe;
    logic       rdStrobe;
    logic       srStrobe;
    logic [7:0] busData;
    logic       ackIn;
    logic       ackInRise;
    logic       cmdRise;
    logic       wrRise;
    logic       addrRise;

    assign addrStrobe = pinSync_q[13];
    assign cmdStrobe  = pinSync_q[12];
    assign wrStrobe   = pinSync_q[11];
    assign rdStrobe   = pinSync_q[10];
    assign srStrobe   = pinSync_q[9];
    assign busData    = pinSync_q[8:1];
    assign ackIn      = pinSync_q[0];
    assign ackInRise  = pinSync_q[0] && !pinSyncPrev_q[0];
    assign cmdRise    = pinSync_q[12] && !pinSyncPrev_q[12];
    assign wrRise     = pinSync_q[11] && !pinSyncPrev_q[11];
    assign addrRise   = pinSync_q[13] && !pinSyncPrev_q[13];

    // Addressed level and setup sequencing
    logic       addressedLevel_q;
    logic       addressedLevel_d;
    logic       setupPending_q;
    logic       setupPending_d;
    logic [3:0] byteAddr_q;

    assign addressedLevel_d = addrRise ? (busData == deviceAddress) : addressedLevel_q;
    logic addrWrite;
    logic dataWrite;
    assign addrWrite = wrRise && addressedLevel_q && setupPending_q;
    assign dataWrite = wrRise && addressedLevel_q && !setupPending_q;
    assign setupPending_d = (cmdRise && addressedLevel_q) ? 1'b1 :
                            (addrWrite ? 1'b0 : setupPending_q);
    // Gates
    logic readGate;
    logic statusReadGate;
    logic cmdGate;
    assign readGate       = rdStrobe && addressedLevel_q;
    assign statusReadGate = srStrobe && addressedLevel_q;
    assign cmdGate        = cmdStrobe && addressedLevel_q;
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            addressedLevel_q <= 1'b0;
            setupPending_q   <= 1'b0;
        end else if (clkEn) begin
            addressedLevel_q <= addressedLevel_d;
            setupPending_q   <= setupPending_d;
        end
    end

    // Command byte and module select registers
    logic armed;
    logic enabled;
    assign armed   = commandByte[`DIO_CMD_ARM_BIT];
    assign enabled = commandByte[`DIO_CMD_ENABLE_BIT];
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            commandByte    <= `DIO_CMD_RESET;
            moduleSelect   <= 4'h0;
            byteAddr_q     <= 4'h0;
            moduleReadMode <= 1'b0;
            outputData     <= 8'h00;
        end else if (clkEn) begin
            if (cmdRise && addressedLevel_q) begin
                commandByte    <= busData;
                moduleReadMode <= busData[`DIO_CMD_READ_BIT];
            end
            if (addrWrite) begin
                moduleSelect <= busData[7:4];
                byteAddr_q   <= busData[3:0];
            end
            if (dataWrite) begin
                outputData <= busData;
            end
        end
    end

    byte_select_decoder u_dec (
        .clk_sys    (clk_sys),
        .rst_b      (rst_b),
        .clkEn      (clkEn),
        .strobe     (dataWrite && !moduleReadMode),
        .byteAddr   (byteAddr_q),
        .byteSelect (byteSelect)
    );

    // Module ack check and input capture after address write
    logic [3:0] ackWait_q;
    logic [7:0] inputData_q;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            ackWait_q         <= 4'h0;
            missingModuleFlag <= 1'b0;
            inputData_q       <= 8'h00;
        end else if (clkEn) begin
            if (addrWrite) begin
                ackWait_q         <= `DIO_ACK_WAIT_CYCLES;
                missingModuleFlag <= 1'b0;
            end else if (ackWait_q != 4'h0) begin
                if (moduleAck) begin
                    ackWait_q <= 4'h0;
                    inputData_q <= inputModuleData;
                end else if (ackWait_q == 4'h1) begin
                    missingModuleFlag <= 1'b1;
                    ackWait_q         <= 4'h0;
                end else begin
                    ackWait_q <= ackWait_q - 4'h1;
                end
            end
        end
    end

    // Busy: set on address or data write, clears on completion
    dio_ctrl_pkg::xfer_state_t xfer_q;
    dio_ctrl_pkg::xfer_state_t xfer_d;
    logic busyStart;
    assign busyStart = dataWrite || addrWrite;
    always_comb begin
        xfer_d = xfer_q;
        unique case (xfer_q)
            dio_ctrl_pkg::XFER_IDLE: begin
                if (busyStart) xfer_d = dio_ctrl_pkg::XFER_BUSY;
            end
            dio_ctrl_pkg::XFER_WAIT: begin
                xfer_d = dio_ctrl_pkg::XFER_IDLE;
            end
            dio_ctrl_pkg::XFER_BUSY: begin
                if (transferDone) xfer_d = dio_ctrl_pkg::XFER_WAIT;
            end
            default: xfer_d = dio_ctrl_pkg::XFER_IDLE;
        endcase
    end

    logic readyEvent;
    assign readyEvent = (xfer_q == dio_ctrl_pkg::XFER_WAIT);
    assign transferBusyFlag = (xfer_q == dio_ctrl_pkg::XFER_BUSY);

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            xfer_q <= dio_ctrl_pkg::XFER_IDLE;
        end else if (clkEn) begin
            xfer_q <= xfer_d;
        end
    end

    // External interrupt pin synchroniser
    logic extMeta_q;
    logic extSync_q;
    logic extPrev_q;
    logic extEvent;
    assign extEvent = extSync_q && !extPrev_q;
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            extMeta_q       <= 1'b0;
            extSync_q       <= 1'b0;
            extPrev_q       <= 1'b0;
            externalIntFlag <= 1'b0;
        end else if (clkEn) begin
            extMeta_q <= externalInt;
            extSync_q <= extMeta_q;
            extPrev_q <= extSync_q;
            if (extEvent) begin
                externalIntFlag <= 1'b1;
            end else if (cmdRise && addressedLevel_q) begin
                externalIntFlag <= 1'b0;
            end
        end
    end

    // Interrupt queue
    logic queued_q;
    logic ackCapture;
    logic ackSyncPulse;
    assign ackCapture   = ackInRise && queued_q && enabled;
    assign ackSyncPulse = ackCapture;
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            queued_q <= 1'b0;
        end else if (clkEn) begin
            if (!armed) begin
                queued_q <= 1'b0;
            end else if (readyEvent || extEvent) begin
                queued_q <= 1'b1;
            end else if (ackSyncPulse) begin
                queued_q <= 1'b0;
            end
        end
    end
    logic ackHeld_q;
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            ackHeld_q <= 1'b0;
        end else if (clkEn) begin
            ackHeld_q <= ackCapture ? 1'b1 : (ackIn ? ackHeld_q : 1'b0);
        end
    end

    assign attentionRequest   = queued_q && enabled;
    assign requestAckChainOut = ackIn && !attentionRequest && !ackHeld_q && !ackCapture;

    // Response mux: sync and return lines from flops
    logic [15:0] statusWord;
    always_comb begin
        statusWord = 16'h0000;
        statusWord[`DIO_STAT_EXTINT_BIT] = externalIntFlag;
        statusWord[`DIO_PSW_BUSY_BIT]    = transferBusyFlag;
        statusWord[`DIO_PSW_EXAMINE_BIT] = externalIntFlag;
        statusWord[`DIO_PSW_MISSING_BIT] = missingModuleFlag;
    end
    logic        syncD;
    logic [15:0] returnD;
    assign syncD = readGate || statusReadGate || cmdGate || (ackHeld_q && ackIn)
                 || (addrStrobe && (busData == deviceAddress))
                 || (wrStrobe && addressedLevel_q);
    assign returnD = readGate ? {8'h00, inputData_q} :
                     statusReadGate ? statusWord :
                     (ackHeld_q && ackIn) ? {8'h00, deviceAddress} : 16'h0000;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            busRsp <= '0;
        end else if (clkEn) begin
            busRsp.transferSyncReply <= syncD;
            busRsp.readReturnLines   <= returnD;
        end
    end

    a_read_gate_sync: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (clkEn && readGate) |=> busRsp.transferSyncReply)
        else $error("Read gate without sync");
    a_status_word_bits: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (clkEn && statusReadGate && !readGate) |=>
        busRsp.readReturnLines[13] == $past(externalIntFlag))
        else $error("Examine bit wrong");
    a_status_needs_addr: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (clkEn && srStrobe && !addressedLevel_q && !readGate && !cmdGate) |=>
        busRsp.readReturnLines == 16'h0000)
        else $error("Status returned unaddressed");
    a_atten_enable: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (clkEn && armed && enabled && !cmdRise && (readyEvent || extEvent)) |=> attentionRequest)
        else $error("Enabled interrupt not signalled");
    a_atten_holds: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (clkEn && attentionRequest && !ackCapture && !cmdRise) |=> attentionRequest)
        else $error("Attention dropped early");
    a_disarm_clear: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (clkEn && !armed) |=> !queued_q)
        else $error("Queue set while disarmed");
    a_ready_on_clear: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (clkEn && armed && $fell(transferBusyFlag)) |=> ##[0:1] queued_q)
        else $error("Ready interrupt lost");
    a_ext_flag_set: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (clkEn && extEvent) |=> externalIntFlag)
        else $error("External flag not set");
    a_ack_blocked: assert property (@(posedge clk_sys) disable iff (!rst_b)
        attentionRequest |-> !requestAckChainOut)
        else $error("Acknowledge passed while requesting");
    a_ack_returns_addr: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (clkEn && ackCapture) |=> ##1 (busRsp.readReturnLines[7:0] == deviceAddress))
        else $error("Ack address not returned");
    c_read_done:   cover property (@(posedge clk_sys) readGate ##1 busRsp.transferSyncReply);
    c_status_read: cover property (@(posedge clk_sys) statusReadGate);
    c_ack_capture: cover property (@(posedge clk_sys) ackCapture);
    c_missing:     cover property (@(posedge clk_sys) $rose(missingModuleFlag));

endmodule

`default_nettype wire

/* test/io_module_model.sv */
`timescale 1ns/10ps
`default_nettype none

module io_module_model #(
    parameter logic [3:0] MISSING = 4'hf
) (
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    input  wire logic [3:0] moduleSelect,
    input  wire logic       busy,
    input  wire logic       doneGo,
    output logic            moduleAck,
    output logic [7:0]      inputModuleData,
    output logic            transferDone
);
    logic [1:0] busyQ;
    logic       goQ;
    logic       busyRise;

    assign busyRise = busyQ[0] && !busyQ[1];

    always_ff @(posedge clk_sys) begin
        busyQ <= {busyQ[0], busy};
        goQ <= doneGo;
        moduleAck <= rst_b && busyRise && moduleSelect != MISSING;
        transferDone <= rst_b && busy && doneGo && !goQ;
        // Lines not driven show a changing pattern, never the old value
        if (!rst_b) begin
            inputModuleData <= 8'h00;
        end else if (busyRise) begin
            inputModuleData <= {moduleSelect, ~moduleSelect} ^ 8'h5a;
        end else begin
            inputModuleData <= ~inputModuleData;
        end
    end
endmodule

`default_nettype wire

/* test/tb.sv */
`timescale 1ns/10ps
`default_nettype none

module tb;
    localparam logic [7:0] DEV = 8'h2c;
    logic                   clk_sys;
    logic                   rst_b;
    dio_ctrl_pkg::bus_req_t busReq;
    dio_ctrl_pkg::bus_rsp_t busRsp;
    dio_ctrl_pkg::bus_rsp_t rsp;
    logic                   chainIn;
    logic                   chainOut;
    logic                   extInt;
    logic                   modAck;
    logic [7:0]             modData;
    logic                   xferDone;
    logic                   doneGo;
    logic                   atn;
    logic [7:0]             outData;
    logic [15:0]            byteSel;
    logic [15:0]            seenSel;
    logic [3:0]             modSel;
    logic                   rdMode;
    logic [7:0]             cmdByte;
    logic                   busy;
    logic                   extFlag;
    logic                   missFlag;
    int                     nSel;
    int                     num_errors;
    int                     n_compared;
    logic [31:0]            seed;

    dio_ctrl_host_port DUT (
        .clk_sys(clk_sys), .rst_b(rst_b), .clkEn(1'b1), .busReq(busReq),
        .requestAckChainIn(chainIn), .deviceAddress(DEV), .externalInt(extInt),
        .moduleAck(modAck), .inputModuleData(modData), .transferDone(xferDone),
        .busRsp(busRsp), .requestAckChainOut(chainOut), .attentionRequest(atn),
        .outputData(outData), .byteSelect(byteSel), .moduleSelect(modSel),
        .moduleReadMode(rdMode), .commandByte(cmdByte), .transferBusyFlag(busy),
        .externalIntFlag(extFlag), .missingModuleFlag(missFlag)
    );

    io_module_model PARTNER (
        .clk_sys(clk_sys), .rst_b(rst_b), .moduleSelect(modSel), .busy(busy),
        .doneGo(doneGo), .moduleAck(modAck), .inputModuleData(modData),
        .transferDone(xferDone)
    );

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        if (byteSel !== 16'h0000) begin
            seenSel <= byteSel;
            nSel <= nSel + 1;
        end
    end

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic [7:0] expData(input logic [3:0] m);
        return {m, ~m} ^ 8'h5a;
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, msg, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // Kind 0 address, 1 command, 2 write, 3 read, 4 status
    task automatic xfer(input int k, input logic [7:0] d, input logic exp);
        int i;
        @(posedge clk_sys);
        busReq <= dio_ctrl_pkg::bus_req_t'({5'h10 >> k, d});
        for (i = 0; i < 12 && busRsp.transferSyncReply !== 1'b1; i++) @(posedge clk_sys);
        rsp = busRsp;
        check(rsp.transferSyncReply, exp, "sync");
        busReq <= '0;
        for (i = 0; i < 12 && busRsp.transferSyncReply !== 1'b0; i++) @(posedge clk_sys);
        check(busRsp.transferSyncReply, 1'b0, "sync drop");
    endtask

    task automatic setup(input logic [7:0] cmd, input logic [7:0] modByte);
        xfer(0, DEV, 1'b1);
        xfer(1, cmd, 1'b1);
        xfer(0, DEV, 1'b1);
        xfer(2, modByte, 1'b1);
    endtask

    task automatic release_done();
        doneGo <= 1'b1;
        cycles(3);
        doneGo <= 1'b0;
        cycles(3);
    endtask

    initial begin
        logic [7:0] mb;
        logic [7:0] dat;
        int         i;
        int         nBase;
        busReq = '0;
        rst_b = 1'b0;
        chainIn = 1'b0;
        extInt = 1'b0;
        doneGo = 1'b0;
        num_errors = 0;
        n_compared = 0;
        seed = 32'd5;
        cycles(2);
        rst_b <= 1'b1;
        cycles(1);
        check({busy, extFlag, missFlag, atn}, 4'h0, "reset flags");
        xfer(0, 8'h11, 1'b0);
        xfer(3, 8'h00, 1'b0);
        xfer(4, 8'h00, 1'b0);
        for (i = 0; i < 6; i++) begin
            seed = xorshift(seed);
            mb = {1'b0, seed[2:0], (i == 0) ? 4'h0 : (i == 1) ? 4'hf : seed[7:4]};
            dat = seed[15:8];
            setup(8'h40, mb);
            release_done();
            xfer(0, DEV, 1'b1);
            nBase = nSel;
            xfer(2, dat, 1'b1);
            check(seenSel, 16'h0001 << mb[3:0], "byte select");
            check(16'(nSel - nBase), 16'h0001, "one pulse");
            check(outData, dat, "out data");
            release_done();
            setup(8'h80, mb);
            check({rdMode, cmdByte}, 9'h180, "read command");
            release_done();
            xfer(0, DEV, 1'b1);
            xfer(3, 8'h00, 1'b1);
            check(rsp.readReturnLines[7:0], expData(mb[7:4]), "read data");
        end
        setup(8'h40, 8'h23);
        xfer(0, DEV, 1'b1);
        xfer(4, 8'h00, 1'b1);
        check({rsp.readReturnLines[15], rsp.readReturnLines[12]}, 2'b01, "busy st");
        release_done();
        setup(8'h40, 8'hf0);
        cycles(12);
        check(missFlag, 1'b1, "missing");
        xfer(0, DEV, 1'b1);
        xfer(4, 8'h00, 1'b1);
        check(rsp.readReturnLines[15], 1'b1, "missing st");
        release_done();
        setup(8'h43, 8'h11);
        check(atn, 1'b0, "no atn busy");
        release_done();
        check(atn, 1'b1, "ready atn");
        chainIn <= 1'b1;
        for (i = 0; i < 12 && busRsp.transferSyncReply !== 1'b1; i++) @(posedge clk_sys);
        check(busRsp.readReturnLines[7:0], DEV, "ack addr");
        check({chainOut, atn}, 2'b00, "chain held");
        chainIn <= 1'b0;
        cycles(6);
        setup(8'h40, 8'h11);
        release_done();
        check(atn, 1'b0, "disarmed");
        chainIn <= 1'b1;
        cycles(5);
        check(chainOut, 1'b1, "chain pass");
        chainIn <= 1'b0;
        xfer(0, DEV, 1'b1);
        xfer(1, 8'h01, 1'b1);
        extInt <= 1'b1;
        cycles(6);
        check({extFlag, atn}, 2'b10, "ext armed");
        extInt <= 1'b0;
        xfer(0, DEV, 1'b1);
        xfer(4, 8'h00, 1'b1);
        check({rsp.readReturnLines[13], rsp.readReturnLines[3]}, 2'b11, "ext st");
        xfer(0, DEV, 1'b1);
        xfer(1, 8'h03, 1'b1);
        check({extFlag, atn}, 2'b01, "cmd clear");
        xfer(0, DEV, 1'b1);
        xfer(1, 8'h00, 1'b1);
        check(atn, 1'b0, "disable");
        finish_test();
    end

    initial begin
        cycles(60000);
        num_errors++;
        finish_test();
    end
endmodule

`default_nettype wire
